// file: hw/dals_defines.svh
// Purpose: Constants for the loop lock sequencer
// Assumes: 10 MHz core clock, three loop pairs (index 0..2, index 2 is the third)
`ifndef DALS_DEFINES_SVH
`define DALS_DEFINES_SVH
`define DALS_NUM_W        40
`define DALS_PDEN_W       24
`define DALS_PHASE_W      16
`define DALS_STEP_W       32
`define DALS_LOOPS        3
`define DALS_THIRD        2
`define DALS_CLK_NS       100
`define DALS_QUAL_NS      1000000
`define DALS_QUAL_CYC     ((`DALS_QUAL_NS + `DALS_CLK_NS - 1) / `DALS_CLK_NS)
`define DALS_ALOCK_NS     20000
`define DALS_ALOCK_CYC    ((`DALS_ALOCK_NS + `DALS_CLK_NS - 1) / `DALS_CLK_NS)
`define DALS_CNT_W        20
`define DALS_FILT_SHIFT   4
`define DALS_LOCK_TOL     16'h0040
`define DALS_CENTER_NUM   40'h8000000000
`define DALS_FIXED_DEN    40'hFFFFFFFFFF
`define DALS_SRC_XO       1'h0
`define DALS_SRC_CASC     1'h1
`endif

// file: hw/dals_dloop.sv
// Purpose: One digital loop: qualify, first correction, filtered tracking, stepping
// Assumes: Reference valid and phase error come from same-clock logic
// Notes: Numerator output steers the paired analog loop
`timescale 1ns/1ps
`include "dals_defines.svh"
module dals_dloop #(
	parameter int unsigned QUAL_CYC = `DALS_QUAL_CYC
) (
	input  wire logic                       core_clk,
	input  wire logic                       reset,
	input  wire logic                       enable,
	input  wire logic                       refValid,
	input  wire logic [`DALS_PHASE_W-1:0]   phaseErr,
	input  wire logic                       stepUp,
	input  wire logic                       stepDown,
	input  wire logic [`DALS_STEP_W-1:0]    freq_deviation_step,
	input  wire logic [`DALS_NUM_W-1:0]     baseNum,
	output logic      [`DALS_NUM_W-1:0]     numer_q,
	output logic                            locked_q
);
	dals_pkg::dals_dstate_t      state_q;
	logic [`DALS_CNT_W-1:0]      qualCnt_q;
	logic [`DALS_NUM_W-1:0]      errExt;
	logic [`DALS_NUM_W-1:0]      stepExt;
	logic [`DALS_NUM_W-1:0]      errFilt;
	logic                        inTol;

	// Sign-extend phase error, zero-extend step to numerator width
	assign errExt  = {{(`DALS_NUM_W-`DALS_PHASE_W){phaseErr[`DALS_PHASE_W-1]}}, phaseErr};
	assign stepExt = {{(`DALS_NUM_W-`DALS_STEP_W){1'b0}}, freq_deviation_step};
	assign errFilt = $signed(errExt) >>> `DALS_FILT_SHIFT; // Own statement keeps shift arithmetic
	assign inTol   = (phaseErr[`DALS_PHASE_W-1] ? (~phaseErr + 16'h0001) : phaseErr)
		< `DALS_LOCK_TOL;

	// Acquisition sequence
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_q   <= dals_pkg::DALS_D_WAIT;
			qualCnt_q <= '0;
		end else if (!enable || !refValid) begin
			state_q   <= dals_pkg::DALS_D_WAIT;
			qualCnt_q <= '0;
		end else begin
			case (state_q)
				dals_pkg::DALS_D_WAIT: state_q <= dals_pkg::DALS_D_QUAL;
				dals_pkg::DALS_D_QUAL: begin
					qualCnt_q <= qualCnt_q + 1'b1;
					if (qualCnt_q >= QUAL_CYC[`DALS_CNT_W-1:0]) begin
						state_q <= dals_pkg::DALS_D_FIRST;
					end
				end
				dals_pkg::DALS_D_FIRST: state_q <= dals_pkg::DALS_D_TRACK;
				dals_pkg::DALS_D_TRACK: state_q <= dals_pkg::DALS_D_TRACK;
				default: state_q <= dals_pkg::DALS_D_WAIT;
			endcase
		end
	end

	// Numerator: direct cancel first, then filtered, plus steps
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			numer_q <= `DALS_CENTER_NUM;
		end else if (state_q == dals_pkg::DALS_D_FIRST) begin
			numer_q <= baseNum - errExt;
		end else if (state_q == dals_pkg::DALS_D_TRACK) begin
			if (stepUp) begin
				numer_q <= numer_q + stepExt;
			end else if (stepDown) begin
				numer_q <= numer_q - stepExt;
			end else begin
				numer_q <= numer_q - errFilt;
			end
		end else begin
			numer_q <= baseNum;
		end
	end

	// Lock flag
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			locked_q <= 1'b0;
		end else begin
			locked_q <= (state_q == dals_pkg::DALS_D_TRACK) && inTol;
		end
	end

	property p_qual;
		@(posedge core_clk) disable iff (reset)
		(state_q == dals_pkg::DALS_D_FIRST) |-> $past(state_q) == dals_pkg::DALS_D_QUAL;
	endproperty
	a_qual: assert property (p_qual) else $error("acquisition without qualify");

	property p_first;
		@(posedge core_clk) disable iff (reset)
		(state_q == dals_pkg::DALS_D_FIRST && enable && refValid)
			|=> numer_q == $past(baseNum) - $past(errExt);
	endproperty
	a_first: assert property (p_first) else $error("first correction wrong");
endmodule // dals_dloop

// file: hw/dals_pkg.sv
// Purpose: Types for the loop lock sequencer
// Assumes: Constants come from the defines header
// Notes: Mode and state encodings
package dals_pkg;
	typedef enum logic [1:0] {
		DALS_MODE_INDEP   = 2'h0,
		DALS_MODE_CASC_DL = 2'h1,
		DALS_MODE_CASC_AL = 2'h3,
		DALS_MODE_AONLY   = 2'h2
	} dals_mode_t;
	// Gray along idle, hold, lock, free-run
	typedef enum logic [1:0] {
		DALS_A_IDLE = 2'h0,
		DALS_A_HOLD = 2'h1,
		DALS_A_LOCK = 2'h3,
		DALS_A_RUN  = 2'h2
	} dals_astate_t;
	// Gray along wait, qualify, first, track
	typedef enum logic [1:0] {
		DALS_D_WAIT  = 2'h0,
		DALS_D_QUAL  = 2'h1,
		DALS_D_FIRST = 2'h3,
		DALS_D_TRACK = 2'h2
	} dals_dstate_t;
endpackage

// file: hw/dals_seq.sv
// Purpose: Start-up ordering, reference muxes, denominators and steering of three loop pairs
// Assumes: All inputs synchronous to core_clk except refValidPin, synchronised here
// Notes: Index 2 is the third (low-jitter) pair
`timescale 1ns/1ps
`include "dals_defines.svh"
module dals_seq #(
	parameter int unsigned QUAL_CYC  = `DALS_QUAL_CYC,
	parameter int unsigned ALOCK_CYC = `DALS_ALOCK_CYC
) (
	input  wire logic                                core_clk,
	input  wire logic                                reset,
	input  wire logic [1:0]                          modeSel,
	input  wire logic [2:0]                          analog_loop_enable,
	input  wire logic [2:0]                          digitalEnable,
	input  wire logic [5:0]                          analog_loop_start_order,
	input  wire logic [2:0]                          analogRefSrc,
	input  wire logic [5:0]                          analogCascSel,
	input  wire logic [5:0]                          digitalRefSel,
	input  wire logic [1:0]                          refValidPin,
	input  wire logic [47:0]                         phaseErr,
	input  wire logic [2:0]                          denominator_select,
	input  wire logic [71:0]                         progDenom,
	input  wire logic [119:0]                        baseNum,
	input  wire logic [2:0]                          stepUp,
	input  wire logic [2:0]                          stepDown,
	input  wire logic [95:0]                         freq_deviation_step,
	input  wire logic [3:0]                          thirdPostDiv,
	output logic      [119:0]                        analogNum_q,
	output logic      [119:0]                        analogDen_q,
	output logic      [5:0]                          analogRefMux_q,
	output logic      [2:0]                          analogRefCasc_q,
	output logic      [5:0]                          digitalRefMux_q,
	output logic                                     thirdPostBypass_q,
	output logic      [2:0]                          analogLocked_q,
	output logic      [2:0]                          digitalLocked_q
);
	dals_pkg::dals_mode_t          mode;
	dals_pkg::dals_astate_t        aState_q [3];
	logic [`DALS_CNT_W-1:0]        aCnt_q [3];
	logic [1:0]                    rvS1_q;
	logic [1:0]                    rvS2_q;
	logic [1:0]                    rvS3_q;
	logic [1:0]                    refValid_q;
	logic [2:0]                    dlEn;
	logic [2:0]                    dlRefOk;
	logic [2:0]                    aTurn;
	logic [2:0]                    aDone;
	logic [119:0]                  dlNum;
	logic [2:0]                    dlLock;
	logic                          thirdCasc;

	assign mode = dals_pkg::dals_mode_t'(modeSel);

	// Priority number of loop i
	function automatic logic [1:0] prio(input logic [5:0] ord, input int i);
		prio = ord[2*i +: 2];
	endfunction

	// Cascade source of loop i is the third oscillator
	function automatic logic fromThird(input logic [5:0] sel, input int i);
		fromThird = (sel[2*i +: 2] == 2'h2);
	endfunction

	// Reference valid pins: three stages, change taken when stage 2 and 3 agree
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rvS1_q     <= 2'h0;
			rvS2_q     <= 2'h0;
			rvS3_q     <= 2'h0;
			refValid_q <= 2'h0;
		end else begin
			rvS1_q <= refValidPin;
			rvS2_q <= rvS1_q;
			rvS3_q <= rvS2_q;
			for (int b = 0; b < 2; b++) begin
				if (rvS2_q[b] == rvS3_q[b]) begin
					refValid_q[b] <= rvS3_q[b];
				end
			end
		end
	end

	// Any downstream loop cascaded from the third oscillator
	always_comb begin
		thirdCasc = 1'b0;
		for (int i = 0; i < 2; i++) begin
			if (analogRefSrc[i] == `DALS_SRC_CASC && fromThird(analogCascSel, i)) begin
				thirdCasc = 1'b1;
			end
		end
	end

	// Start permission: in analog-only mode, lower start order must be done first
	always_comb begin
		aDone = 3'h0;
		aTurn = 3'h0;
		for (int i = 0; i < 3; i++) begin
			// A loop that has finished locking, or is disabled, lets the next one start
			aDone[i] = (aState_q[i] == dals_pkg::DALS_A_RUN) ||
				!analog_loop_enable[i];
		end
		for (int i = 0; i < 3; i++) begin
			aTurn[i] = 1'b1;
			if (mode == dals_pkg::DALS_MODE_AONLY) begin
				for (int j = 0; j < 3; j++) begin
					if (j != i && prio(analog_loop_start_order, j) <
						prio(analog_loop_start_order, i) && !aDone[j]) begin
						aTurn[i] = 1'b0;
					end
				end
			end
		end
		// Third loop waits for downstream when they cascade from it
		if (thirdCasc && !(aDone[0] && aDone[1])) begin
			aTurn[`DALS_THIRD] = 1'b0;
		end
	end

	// Analog loop state machines, one per pair
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < 3; i++) begin
				aState_q[i] <= dals_pkg::DALS_A_IDLE;
				aCnt_q[i]   <= '0;
			end
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (!analog_loop_enable[i]) begin
					aState_q[i] <= dals_pkg::DALS_A_IDLE;
					aCnt_q[i]   <= '0;
				end else begin
					case (aState_q[i])
						dals_pkg::DALS_A_IDLE: aState_q[i] <= dals_pkg::DALS_A_HOLD;
						dals_pkg::DALS_A_HOLD: begin
							aCnt_q[i] <= '0;
							if (aTurn[i]) begin
								aState_q[i] <= dals_pkg::DALS_A_LOCK;
							end
						end
						dals_pkg::DALS_A_LOCK: begin
							aCnt_q[i] <= aCnt_q[i] + 1'b1;
							if (aCnt_q[i] >= ALOCK_CYC[`DALS_CNT_W-1:0]) begin
								aState_q[i] <= dals_pkg::DALS_A_RUN;
							end
						end
						dals_pkg::DALS_A_RUN: aState_q[i] <= dals_pkg::DALS_A_RUN;
						default: aState_q[i] <= dals_pkg::DALS_A_IDLE;
					endcase
				end
			end
		end
	end

	// Digital loop enables and reference validity
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			dlEn[i] = digitalEnable[i] && (mode != dals_pkg::DALS_MODE_AONLY) &&
				(aState_q[i] == dals_pkg::DALS_A_RUN);
			if (digitalRefSel[2*i +: 2] == 2'h3) begin
				dlRefOk[i] = aState_q[`DALS_THIRD] == dals_pkg::DALS_A_RUN;
			end else if (digitalRefSel[2*i +: 2] == 2'h2) begin
				dlRefOk[i] = aState_q[i == 0 ? 1 : 0] == dals_pkg::DALS_A_RUN;
			end else begin
				dlRefOk[i] = refValid_q[digitalRefSel[2*i]];
			end
		end
	end

	// Three digital loops
	for (genvar g = 0; g < 3; g++) begin : gLoop
		dals_dloop #(.QUAL_CYC(QUAL_CYC)) uLoop (
			.core_clk            (core_clk),
			.reset               (reset),
			.enable              (dlEn[g]),
			.refValid            (dlRefOk[g]),
			.phaseErr            (phaseErr[16*g +: 16]),
			.stepUp              (stepUp[g]),
			.stepDown            (stepDown[g]),
			.freq_deviation_step (freq_deviation_step[32*g +: 32]),
			.baseNum             (baseNum[40*g +: 40]),
			.numer_q             (dlNum[40*g +: 40]),
			.locked_q            (dlLock[g])
		);
	end

	// Analog numerator and denominator per pair
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			analogNum_q <= '0;
			analogDen_q <= '0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (dlEn[i]) begin
					analogNum_q[40*i +: 40] <= dlNum[40*i +: 40];
				end else if (stepUp[i]) begin
					analogNum_q[40*i +: 40] <= analogNum_q[40*i +: 40] +
						{8'h00, freq_deviation_step[32*i +: 32]};
				end else if (stepDown[i]) begin
					analogNum_q[40*i +: 40] <= analogNum_q[40*i +: 40] -
						{8'h00, freq_deviation_step[32*i +: 32]};
				end else if (aState_q[i] == dals_pkg::DALS_A_HOLD) begin
					analogNum_q[40*i +: 40] <= `DALS_CENTER_NUM;
				end else if (aState_q[i] == dals_pkg::DALS_A_IDLE) begin
					analogNum_q[40*i +: 40] <= baseNum[40*i +: 40];
				end
				if (denominator_select[i]) begin
					analogDen_q[40*i +: 40] <= `DALS_FIXED_DEN;
				end else begin
					analogDen_q[40*i +: 40] <= {16'h0000, progDenom[24*i +: 24]};
				end
			end
		end
	end

	// Reference muxes and post-divider bypass
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			analogRefMux_q    <= 6'h00;
			analogRefCasc_q   <= 3'h0;
			digitalRefMux_q   <= 6'h00;
			thirdPostBypass_q <= 1'b0;
		end else begin
			analogRefCasc_q   <= analogRefSrc;
			analogRefMux_q    <= analogCascSel;
			digitalRefMux_q   <= digitalRefSel;
			thirdPostBypass_q <= thirdPostDiv == 4'h1;
		end
	end

	// Lock indications
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			analogLocked_q  <= 3'h0;
			digitalLocked_q <= 3'h0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				analogLocked_q[i] <= aState_q[i] == dals_pkg::DALS_A_RUN;
			end
			digitalLocked_q <= dlLock & dlEn;
		end
	end

	property p_bypass;
		@(posedge core_clk) disable iff (reset)
		##1 thirdPostBypass_q == ($past(thirdPostDiv) == 4'h1);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass wrong");

	property p_den;
		@(posedge core_clk) disable iff (reset)
		!denominator_select[0] |=> analogDen_q[39:0] == {16'h0000, $past(progDenom[23:0])};
	endproperty
	a_den: assert property (p_den) else $error("denominator select wrong");

	property p_order;
		@(posedge core_clk) disable iff (reset)
		($past(mode) == dals_pkg::DALS_MODE_AONLY &&
			$past(analog_loop_enable[1]) &&
			$past(aState_q[0]) == dals_pkg::DALS_A_HOLD &&
			aState_q[0] == dals_pkg::DALS_A_LOCK &&
			$past(analog_loop_start_order[3:2]) < $past(analog_loop_start_order[1:0]))
			|-> $past(aState_q[1]) == dals_pkg::DALS_A_RUN;
	endproperty
	a_order: assert property (p_order) else $error("start order broken");

	property p_third;
		@(posedge core_clk) disable iff (reset)
		(thirdCasc && aState_q[2] == dals_pkg::DALS_A_HOLD && !(aDone[0] && aDone[1]))
			|=> aState_q[2] != dals_pkg::DALS_A_LOCK;
	endproperty
	a_third: assert property (p_third) else $error("third locked too early");

	property p_aonly;
		@(posedge core_clk) disable iff (reset)
		mode == dals_pkg::DALS_MODE_AONLY |=> digitalLocked_q == 3'h0;
	endproperty
	a_aonly: assert property (p_aonly) else $error("digital active in analog-only");

	property p_alock;
		@(posedge core_clk) disable iff (reset)
		analogLocked_q[0] |-> $past(aState_q[0]) == dals_pkg::DALS_A_RUN;
	endproperty
	a_alock: assert property (p_alock) else $error("lock flag wrong");

	// Steering, muxes and held numerators
	property p_hold;
		@(posedge core_clk) disable iff (reset)
		(thirdCasc && aState_q[2] == dals_pkg::DALS_A_HOLD && !dlEn[2] && !stepUp[2] &&
			!stepDown[2]) |=> analogNum_q[119:80] == `DALS_CENTER_NUM;
	endproperty
	a_hold: assert property (p_hold) else $error("third not held at centre");

	property p_denfix;
		@(posedge core_clk) disable iff (reset)
		denominator_select[2] |=> analogDen_q[119:80] == `DALS_FIXED_DEN;
	endproperty
	a_denfix: assert property (p_denfix) else $error("fixed denominator wrong");

	property p_follow;
		@(posedge core_clk) disable iff (reset)
		dlEn[0] |=> analogNum_q[39:0] == $past(dlNum[39:0]);
	endproperty
	a_follow: assert property (p_follow) else $error("numerator not steered");

	property p_casc;
		@(posedge core_clk) disable iff (reset)
		##1 analogRefCasc_q == $past(analogRefSrc);
	endproperty
	a_casc: assert property (p_casc) else $error("analog source wrong");

	property p_mux;
		@(posedge core_clk) disable iff (reset)
		##1 analogRefMux_q == $past(analogCascSel);
	endproperty
	a_mux: assert property (p_mux) else $error("analog cascade select wrong");

	property p_dref;
		@(posedge core_clk) disable iff (reset)
		##1 digitalRefMux_q == $past(digitalRefSel);
	endproperty
	a_dref: assert property (p_dref) else $error("digital reference select wrong");

	property p_indep;
		@(posedge core_clk) disable iff (reset)
		($past(mode) == dals_pkg::DALS_MODE_INDEP && $past(analog_loop_enable[1]) &&
			$past(aState_q[1]) == dals_pkg::DALS_A_RUN)
			|-> aState_q[1] == dals_pkg::DALS_A_RUN;
	endproperty
	a_indep: assert property (p_indep) else $error("free-running loop disturbed");

	property p_dlock;
		@(posedge core_clk) disable iff (reset)
		digitalLocked_q[0] |-> $past(dlEn[0]) && $past(dlLock[0]);
	endproperty
	a_dlock: assert property (p_dlock) else $error("digital lock flag wrong");

	property p_step;
		@(posedge core_clk) disable iff (reset)
		(!dlEn[1] && stepUp[1]) |=> analogNum_q[79:40] ==
			$past(analogNum_q[79:40]) + {8'h00, $past(freq_deviation_step[63:32])};
	endproperty
	a_step: assert property (p_step) else $error("step not applied");

	property p_sync;
		@(posedge core_clk) disable iff (reset)
		refValid_q[0] != $past(refValid_q[0]) |-> $past(rvS2_q[0]) == $past(rvS3_q[0]);
	endproperty
	a_sync: assert property (p_sync) else $error("reference valid taken early");
endmodule // dals_seq

// file: tb/dals_ref_src.sv
// Purpose: Reference clock sources seen by the loop sequencer
// Assumes: Phase error follows the numerator offset from the base value
// Notes: A lost reference gives a meaningless error that changes every cycle
`timescale 1ns/1ps
module dals_ref_src (
	input  wire logic         core_clk,
	input  wire logic [1:0]   refOn,
	input  wire logic [15:0]  errInit,
	input  wire logic [119:0] analogNum_q,
	input  wire logic [119:0] baseNum,
	output logic      [1:0]   refValidPin,
	output logic      [47:0]  phaseErr
);
	logic [15:0] junk_q = 16'h5A3C;

	// Valid levels land off the clock edge, unrelated in phase
	assign #3 refValidPin = refOn;

	// Pattern for a lost reference
	always @(posedge core_clk) begin
		junk_q <= ~junk_q + 16'h0001;
	end

	// Error shrinks as the numerator moves against it, unit gain keeps loop slow
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			phaseErr[16*i +: 16] = refOn[0]
				? errInit + (analogNum_q[40*i +: 16] - baseNum[40*i +: 16])
				: junk_q ^ 16'(i);
		end
	end
endmodule // dals_ref_src

// file: tb/tb_top.sv
// Purpose: Self-checking bench for the loop lock sequencer
// Assumes: Short qualify and lock counts, sources from dals_ref_src
// Notes: Numerator changes are checked against a queue of notes
`timescale 1ns/1ps
`include "dals_defines.svh"
module tb_top;
	localparam int QC = 8;
	localparam int AC = 4;
	logic         core_clk = 1'b0;
	logic         reset    = 1'b1;
	logic [1:0]   modeSel, refOn, refValidPin;
	logic [2:0]   aEn, dEn, aSrc, denSel, stepUp, stepDown, aCasc, aLock, dLock;
	logic [5:0]   startOrd, cascSel, dSel, aMux, dMux;
	logic [71:0]  progDen;
	logic [95:0]  stepVal;
	logic [119:0] baseNum, aNum, aDen;
	logic [47:0]  phaseErr;
	logic [15:0]  errInit;
	logic [3:0]   postDiv;
	logic         bypass;
	logic         watch = 1'b0;
	logic [63:0]  noteQ[$];
	logic [39:0]  prevNum[3];
	logic [39:0]  expNum;
	int           error_cnt = 0;
	int           compares  = 0;
	int           cyc       = 0;
	int           t0;

	dals_seq #(.QUAL_CYC(QC), .ALOCK_CYC(AC)) u_dals_seq (
		.core_clk(core_clk), .reset(reset), .modeSel(modeSel),
		.analog_loop_enable(aEn), .digitalEnable(dEn),
		.analog_loop_start_order(startOrd), .analogRefSrc(aSrc),
		.analogCascSel(cascSel), .digitalRefSel(dSel), .refValidPin(refValidPin),
		.phaseErr(phaseErr), .denominator_select(denSel), .progDenom(progDen),
		.baseNum(baseNum), .stepUp(stepUp), .stepDown(stepDown),
		.freq_deviation_step(stepVal), .thirdPostDiv(postDiv),
		.analogNum_q(aNum), .analogDen_q(aDen), .analogRefMux_q(aMux),
		.analogRefCasc_q(aCasc), .digitalRefMux_q(dMux),
		.thirdPostBypass_q(bypass), .analogLocked_q(aLock), .digitalLocked_q(dLock)
	);

	dals_ref_src u_dals_ref_src (
		.core_clk(core_clk), .refOn(refOn), .errInit(errInit),
		.analogNum_q(aNum), .baseNum(baseNum), .refValidPin(refValidPin),
		.phaseErr(phaseErr)
	);

	// Clock at 10 MHz
	initial begin
		forever #50 core_clk = ~core_clk;
	end

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n = 1);
		repeat (n) @(posedge core_clk);
		#5;
	endtask

	// Bounded wait for an analog or digital lock flag
	task automatic waitHi(input int i, input bit dig);
		int k;
		k = 0;
		while ((dig ? dLock[i] : aLock[i]) !== 1'b1 && k < 300) begin
			tick();
			k++;
		end
		chk(dig ? dLock[i] : aLock[i], 1'b1);
	endtask

	task automatic idle();
		modeSel = 2'h0;
		{aEn, dEn, aSrc, denSel, stepUp, stepDown} = 18'h0;
		{startOrd, cascSel, dSel} = 18'h0;
		progDen = 72'h0;
		stepVal = 96'h0;
		baseNum = {3{`DALS_CENTER_NUM}};
		postDiv = 4'h0;
		refOn = 2'h0;
		errInit = 16'h0;
	endtask

	task automatic doRst();
		reset = 1'b1;
		idle();
		tick(5);
		reset = 1'b0;
		tick();
	endtask

	task automatic give_verdict();
		$display("compares=%0d error_cnt=%0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// Numerator changes pop the oldest note, looked at mid-cycle
	always @(negedge core_clk) begin
		for (int i = 0; i < 3; i++) begin
			if (watch && aNum[40*i +: 40] !== prevNum[i]) begin
				if (noteQ.size() == 0) chk({2'(i), aNum[40*i +: 40]}, {64{1'b1}});
				else chk({2'(i), aNum[40*i +: 40]}, noteQ.pop_front());
			end
			prevNum[i] = aNum[40*i +: 40];
		end
	end

	// Hang guard
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			give_verdict();
		end
	end

	initial begin
		idle();
		void'($urandom(39));
		tick(5);
		chk(|{aNum, aDen, aMux, aCasc, dMux, bypass, aLock, dLock}, 1'b0);
		reset = 1'b0;
		tick();
		// Denominator choice per loop, both polarities
		progDen = 72'({$urandom(), $urandom(), $urandom()});
		for (int p = 0; p < 2; p++) begin
			denSel = p ? 3'h2 : 3'h5;
			tick(2);
			for (int i = 0; i < 3; i++) begin
				chk(aDen[40*i +: 40], denSel[i] ? 40'hFFFFFFFFFF : {16'h0, progDen[24*i +: 24]});
			end
		end
		// Post-divider bypass only for a setting of one
		for (int d = 0; d < 16; d++) begin
			postDiv = 4'(d);
			tick(2);
			chk(bypass, d == 1);
		end
		// Reference muxes, never one source to both sides of a pair
		aSrc = 3'h3;
		cascSel = 6'h0A;
		dSel = 6'h18;
		tick(2);
		chk(aCasc, 3'h3);
		chk(aMux, 6'h0A);
		chk(dMux, 6'h18);
		// Analog-only start order 1, 2, 0
		doRst();
		modeSel = 2'h2;
		startOrd = 6'h12;
		aEn = 3'h7;
		dEn = 3'h7;
		refOn = 2'h1;
		waitHi(1, 1'b0);
		chk(aLock[0] | aLock[2], 1'b0);
		waitHi(2, 1'b0);
		chk(aLock[0], 1'b0);
		waitHi(0, 1'b0);
		// Stepping with digital loops idle
		expNum = baseNum[79:40];
		watch = 1'b1;
		for (int k = 0; k < 6; k++) begin
			stepVal[63:32] = $urandom() & 32'h00FFFFFF;
			if ($urandom() % 2) begin
				stepUp = 3'h2;
				expNum += {8'h0, stepVal[63:32]};
			end else begin
				stepDown = 3'h2;
				expNum -= {8'h0, stepVal[63:32]};
			end
			noteQ.push_back({22'h0, 2'h1, expNum});
			tick();
			stepUp = 3'h0;
			stepDown = 3'h0;
			tick(3);
		end
		chk(noteQ.size(), 0);
		watch = 1'b0;
		// Cascade from the third oscillator, loop 0 powered down
		doRst();
		modeSel = 2'h3;
		aSrc = 3'h2;
		cascSel = 6'h08;
		aEn = 3'h6;
		waitHi(1, 1'b0);
		chk(aLock[2], 1'b0);
		waitHi(2, 1'b0);
		aEn = 3'h4;
		tick(2);
		chk(aLock[1], 1'b0);
		aEn = 3'h6;
		waitHi(1, 1'b0);
		// Independent digital acquisition on loop 0
		doRst();
		aEn = 3'h3;
		dEn = 3'h1;
		errInit = 16'(1 + $urandom() % 15);
		waitHi(0, 1'b0);
		waitHi(1, 1'b0);
		chk(dLock[0], 1'b0);
		watch = 1'b1;
		noteQ.push_back({22'h0, 2'h0, baseNum[39:0] - {24'h0, errInit}});
		t0 = cyc;
		refOn = 2'h1;
		waitHi(0, 1'b1);
		chk(cyc - t0 > QC, 1'b1);
		tick(3);
		chk(noteQ.size(), 0);
		watch = 1'b0;
		refOn = 2'h0;
		tick(20);
		chk(dLock[0], 1'b0);
		chk(aLock, 3'h3);
		give_verdict();
	end
endmodule // tb_top
